// File: inc/ptcc_defs.svh
// Purpose: offsets, field positions and reset values of the timer channel
// Assumes: word-aligned registers on a 32-bit classic Wishbone bus
// Notes: the word index is the byte address divided by four
`ifndef PTCC_DEFS_SVH
`define PTCC_DEFS_SVH
// register word indices
`define PTCC_IDX_CTL 6'h00
`define PTCC_IDX_LIM 6'h01
`define PTCC_IDX_CNT 6'h02
`define PTCC_IDX_STA 6'h03
`define PTCC_IDX_CCC 6'h04
`define PTCC_IDX_CCV 6'h0A
`define PTCC_IDX_IFL 6'h10
`define PTCC_IDX_IEN 6'h11
// control register fields
`define PTCC_CTL_RUN 0
`define PTCC_CTL_PRESET 1
`define PTCC_CTL_DIR_LO 2
`define PTCC_CTL_SINGLE 4
`define PTCC_CTL_PEND 8
// direction codes
`define PTCC_DIR_UP 2'h0
`define PTCC_DIR_DOWN 2'h1
// flag positions: compare flags start at bit 2
`define PTCC_FLG_MAX 0
`define PTCC_FLG_ZERO 1
`define PTCC_FLG_CC0 2
// reset values
`define PTCC_RST_MAX 16'hFFFF
`define PTCC_RST_ZERO 16'h0000
// compare load timing codes
`define PTCC_LD_NOW 3'h0
`define PTCC_LD_ZERO 3'h1
`define PTCC_LD_MAX 3'h2
`define PTCC_LD_BOTH 3'h3
`define PTCC_LD_MATCH 3'h4
`endif

// File: inc/ptcc_pkg.sv
// Purpose: types shared by the timer channel modules
// Assumes: constants live in ptcc_defs.svh
// Notes: nothing here is imported, every use is scoped
package ptcc_pkg;
   // counter phase, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_UP = 3'b010,
      ST_DOWN = 3'b100
   } ptcc_state_t;
   // channel control fields
   typedef struct packed {
      logic single;
      logic [1:0] dir;
      logic run;
   } ptcc_ctrl_t;
   // per-circuit control fields
   typedef struct packed {
      logic [2:0] load;
      logic func;
   } ptcc_ccctl_t;
endpackage

// File: verification/pwm_timer_counter_compare_test.sv
// Purpose: self-checking bench for one pwm timer channel over wishbone
// Assumes: count clock pin toggled by the bench, slow enough for sync
// Notes: each scenario is its own task and judges its own readback
`timescale 1ns/1ps
`default_nettype none
`include "ptcc_defs.svh"
module pwm_timer_counter_compare_test;
   logic CLK_SYS; // system clock, 20 ns
   logic NRST; // async reset, active low
   logic cyc, stb, we; // wishbone request
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat;
   logic [31:0] rdat;
   logic ack;
   logic cnt_clk; // count clock pin
   logic [1:0] cap_in; // capture trigger pins
   logic [1:0] wave, wave_oe;
   logic irq;
   logic wave_seen; // sticky: match pulse is one cycle wide
   int n_fail, n_tests;

   ptcc_top #(.NCC(2)) u_ptcc_top (
      .CLK_SYS(CLK_SYS), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .TIMER_COUNT_CLOCK(cnt_clk),
      .CAPTURE_TRIGGER_IN(cap_in), .TIMER_WAVE_OUT(wave),
      .TIMER_WAVE_OE(wave_oe), .IRQ(irq));

   // clock generator
   initial begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end

   // catch the one-cycle match pulse of circuit 0
   always @(posedge CLK_SYS) begin
      if (wave[0] === 1'b1) begin
         wave_seen <= 1'b1;
      end
   end

   // one compare; a mismatch is counted at once
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // classic single cycle; held until ack is sampled high
   // no local limit: a missing ack is ended by the watchdog
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] q);
      @(posedge CLK_SYS);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      dat <= {16'h0000, d};
      do begin
         @(posedge CLK_SYS);
      end while (ack !== 1'b1);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge CLK_SYS); // idle cycle between requests
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      wb(1'b1, a, d, q);
   endtask

   // read, mask and compare
   task automatic rdc(input logic [7:0] a, input logic [15:0] m,
                      input logic [15:0] e);
      logic [15:0] q;
      wb(1'b0, a, 16'h0000, q);
      check(q & m, e);
   endtask

   // one count clock period; pin held high and low well over two cycles
   task automatic tick();
      cnt_clk <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      cnt_clk <= 1'b0;
      repeat (6) @(posedge CLK_SYS);
   endtask

   // reset values, unmapped place, idle status
   task automatic t_reset();
      rdc(8'h04, 16'hFFFF, 16'hFFFF);
      rdc(8'h08, 16'hFFFF, 16'h0000);
      rdc(8'h0C, 16'hFFFF, 16'h0002);
      wr(8'h80, 16'h1234);
      rdc(8'h80, 16'hFFFF, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
   endtask

   // repeat up, limit 2, then a raised limit while running
   task automatic t_repeat_up();
      wr(8'h04, 16'h0002);
      wr(8'h40, 16'h000F); // clear flags before enabling
      wr(8'h44, 16'h0001);
      wr(8'h00, 16'h0002);
      wr(8'h00, 16'h0001); // run
      rdc(8'h0C, 16'h0003, 16'h0003);
      for (int i = 1; i <= 4; i++) begin
         tick();
         rdc(8'h08, 16'hFFFF, 16'(i % 3));
      end
      rdc(8'h40, 16'h0001, 16'h0001);
      check({15'h0000, irq}, 16'h0001);
      wr(8'h44, 16'h0000); // masked: flag stays, request drops
      @(posedge CLK_SYS); // request is registered one cycle late
      check({15'h0000, irq}, 16'h0000);
      wr(8'h04, 16'h0005);
      rdc(8'h00, 16'h0100, 16'h0100);
      tick();
      rdc(8'h00, 16'h0100, 16'h0000);
      tick();
      rdc(8'h08, 16'hFFFF, 16'h0003);
      wr(8'h00, 16'h0000);
      rdc(8'h0C, 16'h0001, 16'h0000);
      wr(8'h40, 16'h000F);
      rdc(8'h40, 16'h000F, 16'h0000);
   endtask

   // single-pass down, limit 3: preset loads limit, halts after reload
   task automatic t_single_down();
      wr(8'h04, 16'h0003);
      wr(8'h00, 16'h0016);
      rdc(8'h08, 16'hFFFF, 16'h0003);
      wr(8'h00, 16'h0015);
      rdc(8'h0C, 16'h0003, 16'h0001);
      for (int i = 1; i <= 4; i++) begin
         tick();
         rdc(8'h08, 16'hFFFF, 16'((7 - i) % 4));
      end
      rdc(8'h0C, 16'h0001, 16'h0000);
      tick();
      rdc(8'h08, 16'hFFFF, 16'h0003);
   endtask

   // single-pass up/down, limit 2: 1,2,1,0 then halt
   task automatic t_single_updown();
      wr(8'h04, 16'h0002);
      wr(8'h00, 16'h001A);
      wr(8'h00, 16'h0019);
      tick();
      rdc(8'h0C, 16'h0003, 16'h0003);
      tick();
      rdc(8'h08, 16'hFFFF, 16'h0002);
      tick();
      rdc(8'h0C, 16'h0003, 16'h0001);
      tick();
      rdc(8'h08, 16'hFFFF, 16'h0000);
      rdc(8'h0C, 16'h0001, 16'h0000);
      tick();
      rdc(8'h08, 16'hFFFF, 16'h0000);
   endtask

   // circuit 0 compares at 2, circuit 1 captures the count
   task automatic t_compare();
      wr(8'h10, 16'h0000);
      wr(8'h14, 16'h0001);
      @(posedge CLK_SYS); // enable register follows the write a cycle late
      check({14'h0000, wave_oe}, 16'h0001);
      wr(8'h28, 16'h0002);
      wr(8'h04, 16'h0003);
      wr(8'h40, 16'h000F);
      wr(8'h00, 16'h0002);
      wr(8'h00, 16'h0001);
      wave_seen <= 1'b0;
      tick();
      check({15'h0000, wave_seen}, 16'h0000);
      tick();
      check({15'h0000, wave_seen}, 16'h0001);
      rdc(8'h40, 16'h0004, 16'h0004);
      cap_in <= 2'b10;
      repeat (4) @(posedge CLK_SYS);
      cap_in <= 2'b00;
      repeat (4) @(posedge CLK_SYS);
      rdc(8'h2C, 16'hFFFF, 16'h0002);
      rdc(8'h40, 16'h0008, 16'h0008);
      check({15'h0000, wave[1]}, 16'h0000);
      // buffer loads only at the limit: no match on the old-period 3
      wr(8'h10, 16'h0020);
      wr(8'h28, 16'h0003);
      wave_seen <= 1'b0;
      tick();
      check({15'h0000, wave_seen}, 16'h0000);
      repeat (4) tick();
      check({15'h0000, wave_seen}, 16'h0001);
      wr(8'h00, 16'h0000);
   endtask

   // the one place where the run ends
   task automatic summarize();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // watchdog: scenarios need well under 5000 cycles
   initial begin
      repeat (20000) @(posedge CLK_SYS);
      n_fail++;
      summarize();
   end

   // main sequence
   initial begin
      n_fail = 0;
      n_tests = 0;
      NRST = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0000_0000;
      cnt_clk = 1'b0;
      cap_in = 2'b00;
      wave_seen = 1'b0;
      repeat (6) @(posedge CLK_SYS);
      NRST <= 1'b1;
      t_reset();
      t_repeat_up();
      t_single_down();
      t_single_updown();
      t_compare();
      summarize();
   end
endmodule // pwm_timer_counter_compare_test
`default_nettype wire

// File: verilog/ptcc_cc_unit.sv
// Purpose: one comparator/capture circuit with its compare buffer
// Assumes: count, step and limit events come from the channel counter
// Notes: value register holds the captured count in capture mode
`timescale 1ns/1ps
`default_nettype none
`include "ptcc_defs.svh"
module ptcc_cc_unit (
   input wire logic clk,
   input wire logic nrst,
   input wire ptcc_pkg::ptcc_ccctl_t ctl,
   input wire logic wr,
   input wire logic [15:0] wdata,
   input wire logic step,
   input wire logic at_zero,
   input wire logic at_max,
   input wire logic [15:0] count,
   input wire logic cap_evt,
   output logic [15:0] value,
   output logic match,
   output logic cap_hit
);
   logic [15:0] buf_r; // value the comparator really sees
   logic ld; // transfer written value into the buffer
   // comparator looks at the buffer so a write mid-period cannot glitch
   assign match = !ctl.func && step && (count == buf_r);
   assign cap_hit = ctl.func && cap_evt;
   assign ld = (ctl.load == `PTCC_LD_ZERO) ? at_zero :
               (ctl.load == `PTCC_LD_MAX) ? at_max :
               (ctl.load == `PTCC_LD_BOTH) ? (at_zero | at_max) :
               (ctl.load == `PTCC_LD_MATCH) ? match : 1'b1;
   // value register: software write, or captured count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         value <= `PTCC_RST_ZERO;
      end else if (cap_hit) begin
         value <= count;
      end else if (wr) begin
         value <= wdata;
      end
   end
   // buffer load at the chosen moment
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         buf_r <= `PTCC_RST_ZERO;
      end else if (ld) begin
         buf_r <= value;
      end
   end
endmodule // ptcc_cc_unit
`default_nettype wire

// File: verilog/ptcc_sync_edge.sv
// Purpose: two-flop synchroniser with rising edge pulse per bit
// Assumes: inputs are asynchronous pins
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ptcc_sync_edge #(parameter int W = 1) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] rise
);
   logic [W-1:0] s1_r; // metastability stage
   logic [W-1:0] s2_r; // stable copy
   logic [W-1:0] s3_r; // previous stable copy
   // three stages, edge taken from the stable pair only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign rise = s2_r & ~s3_r;
endmodule // ptcc_sync_edge
`default_nettype wire

// File: verilog/ptcc_top.sv
// Purpose: one channel of a 16-bit PWM timer with compare/capture
// Assumes: count clock arrives as a pin and is sampled on CLK_SYS
// Notes: registers reached over classic Wishbone, one word each
// Functional notes
// - 16-bit up/down counter, one step per count clock
// - direction field plus single-pass bit, six modes
// - repeat runs until cleared; single-pass halts itself
// - limit register bounds counter to zero..limit
// - report limit update pending flag to software
// - preset clears counter, or loads limit when down
// - counting up past limit clears to zero
// - active bit shows counter running
// - direction bit high counting up, low down
// - repeat up wraps, follows raised or lowered limit
// - single-pass up wraps at limit then halts
// - repeat down reloads limit, new limit after underflow
// - single-pass down reloads limit on underflow, halts
// - repeat up/down bounces, limit changes per phase
// - single-pass up/down halts reaching zero going down
// - per-circuit bit selects compare or capture
// - match asserts output and sets circuit flag
// - limit and zero flags set on reaching them
// - compare against buffer loaded at chosen timing
// - software programs limit, flags, mode, preset, run
// - interrupt only when an enabled flag is set
`timescale 1ns/1ps
`default_nettype none
`include "ptcc_defs.svh"
module ptcc_top #(parameter int NCC = 2) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic TIMER_COUNT_CLOCK,
   input wire logic [NCC-1:0] CAPTURE_TRIGGER_IN,
   output logic [NCC-1:0] TIMER_WAVE_OUT,
   output logic [NCC-1:0] TIMER_WAVE_OE,
   output logic IRQ
);
   localparam int FW = NCC + 2; // flag width

   // merge byte lanes of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [15:0] nw, input logic [1:0] sel);
      merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
   endfunction

   // bus decode
   logic [5:0] idx; // word index
   logic req; // request pending, not yet answered
   logic wr; // write takes effect at the acknowledged edge
   logic [15:0] wd; // low half of write data
   assign idx = WB_ADR_I[7:2];
   assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
   assign wd = WB_DAT_I[15:0];
   logic wr_ctl, wr_lim, wr_ifl, wr_ien; // per-register write strobes
   assign wr_ctl = wr && idx == `PTCC_IDX_CTL;
   assign wr_lim = wr && idx == `PTCC_IDX_LIM;
   assign wr_ifl = wr && idx == `PTCC_IDX_IFL;
   assign wr_ien = wr && idx == `PTCC_IDX_IEN;

   // control state
   ptcc_pkg::ptcc_ctrl_t ctl_r; // run, direction, single-pass
   ptcc_pkg::ptcc_state_t st_r, st_nxt; // counter phase
   logic [15:0] cnt_r, cnt_nxt; // live count value
   logic [15:0] max_r; // active limit
   logic [15:0] shadow_r; // limit written, waiting to apply
   logic pend_r; // limit update pending
   logic [FW-1:0] flag_r; // sticky event flags
   logic [FW-1:0] en_r; // flag enables
   logic step_r; // counter moved last cycle
   logic irq_r; // registered request
   logic halt; // single-pass end point reached

   // mode decode; code 3 behaves as up/down
   logic dn_mode, ud_mode;
   assign dn_mode = ctl_r.dir == `PTCC_DIR_DOWN;
   assign ud_mode = ctl_r.dir[1];
   logic preset_w; // preset write pulse, never stored
   assign preset_w = wr_ctl && WB_SEL_I[0] && wd[`PTCC_CTL_PRESET];
   // preset obeys the direction written with it, so one write may do both
   logic preset_dn;
   assign preset_dn = wd[`PTCC_CTL_DIR_LO +: 2] == `PTCC_DIR_DOWN;

   // pin sampling: count clock plus capture triggers
   logic [NCC:0] rise;
   logic tick; // one count clock edge
   ptcc_sync_edge #(.W(NCC + 1)) u_sync (
      .clk(CLK_SYS),
      .nrst(NRST),
      .din({CAPTURE_TRIGGER_IN, TIMER_COUNT_CLOCK}),
      .rise(rise)
   );
   assign tick = rise[0];

   // limit applies when idle, at any up step, or at zero going down
   logic apply; // shadow moves into active limit
   logic [15:0] max_eff; // limit seen by this step
   assign apply = pend_r && (st_r == ptcc_pkg::ST_IDLE ||
                  (tick && (st_r == ptcc_pkg::ST_UP || cnt_r == 16'h0000)));
   assign max_eff = apply ? shadow_r : max_r;

   // counter next state
   always_comb begin
      cnt_nxt = cnt_r;
      st_nxt = st_r;
      halt = 1'b0;
      case (st_r)
         ptcc_pkg::ST_IDLE: begin
            if (ctl_r.run) begin
               st_nxt = dn_mode ? ptcc_pkg::ST_DOWN : ptcc_pkg::ST_UP;
            end
         end
         ptcc_pkg::ST_UP: begin
            if (!ctl_r.run) begin
               st_nxt = ptcc_pkg::ST_IDLE;
            end else if (tick) begin
               if (cnt_r > max_eff) begin
                  cnt_nxt = 16'h0000; // lowered limit
               end else if (cnt_r == max_eff && ud_mode) begin
                  // turn round at the limit
                  st_nxt = ptcc_pkg::ST_DOWN;
                  cnt_nxt = (cnt_r == 16'h0000) ? cnt_r : cnt_r - 16'h0001;
               end else if (cnt_r == max_eff) begin
                  cnt_nxt = 16'h0000;
                  halt = ctl_r.single;
               end else begin
                  cnt_nxt = cnt_r + 16'h0001;
               end
            end
         end
         ptcc_pkg::ST_DOWN: begin
            if (!ctl_r.run) begin
               st_nxt = ptcc_pkg::ST_IDLE;
            end else if (tick) begin
               if (cnt_r == 16'h0000 && ud_mode) begin
                  // bounce back up from zero
                  st_nxt = ptcc_pkg::ST_UP;
                  cnt_nxt = (max_eff == 16'h0000) ? cnt_r : 16'h0001;
                  halt = ctl_r.single;
               end else if (cnt_r == 16'h0000) begin
                  cnt_nxt = max_eff; // underflow reload
                  halt = ctl_r.single;
               end else begin
                  cnt_nxt = cnt_r - 16'h0001;
                  halt = ud_mode && ctl_r.single &&
                         cnt_r == 16'h0001;
               end
            end
         end
         default: begin
            st_nxt = ptcc_pkg::ST_IDLE;
         end
      endcase
      if (halt) begin
         st_nxt = ptcc_pkg::ST_IDLE;
      end
      // preset has the last word on the count value
      if (preset_w) begin
         cnt_nxt = preset_dn ? max_eff : 16'h0000;
         if (st_r != ptcc_pkg::ST_IDLE && !halt) begin
            st_nxt = preset_dn ? ptcc_pkg::ST_DOWN : ptcc_pkg::ST_UP;
         end
      end
   end

   // counter registers
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         cnt_r <= `PTCC_RST_ZERO;
         st_r <= ptcc_pkg::ST_IDLE;
         step_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         st_r <= st_nxt;
         step_r <= tick && ctl_r.run && st_r != ptcc_pkg::ST_IDLE;
      end
   end

   // control register; hardware halt clears run unless software sets it
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         ctl_r <= '0;
      end else if (wr_ctl && WB_SEL_I[0]) begin
         ctl_r.run <= wd[`PTCC_CTL_RUN];
         ctl_r.dir <= wd[`PTCC_CTL_DIR_LO +: 2];
         ctl_r.single <= wd[`PTCC_CTL_SINGLE];
      end else if (halt) begin
         ctl_r.run <= 1'b0;
      end
   end

   // limit: written into a shadow, flagged pending until applied
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         max_r <= `PTCC_RST_MAX;
         shadow_r <= `PTCC_RST_MAX;
         pend_r <= 1'b0;
      end else begin
         if (apply) begin
            max_r <= shadow_r;
         end
         if (wr_lim) begin
            shadow_r <= merge16(shadow_r, wd, WB_SEL_I[1:0]);
            pend_r <= 1'b1;
         end else if (apply) begin
            pend_r <= 1'b0;
         end
      end
   end

   // comparator/capture circuits
   logic at_max, at_zero; // counter landed on limit or zero
   assign at_max = step_r && cnt_r == max_r;
   assign at_zero = step_r && cnt_r == 16'h0000;
   ptcc_pkg::ptcc_ccctl_t ccc_r [NCC]; // circuit controls
   logic [15:0] ccv [NCC]; // circuit values
   logic [NCC-1:0] match, cap_hit; // circuit events
   genvar g;
   for (g = 0; g < NCC; g++) begin : g_cc
      logic wr_ccv; // value write strobe for this circuit
      assign wr_ccv = wr && idx == `PTCC_IDX_CCV + 6'(g);
      // circuit control register
      always_ff @(posedge CLK_SYS or negedge NRST) begin
         if (!NRST) begin
            ccc_r[g] <= '0;
         end else if (wr && WB_SEL_I[0] && idx == `PTCC_IDX_CCC + 6'(g)) begin
            ccc_r[g].func <= wd[0];
            ccc_r[g].load <= wd[6:4];
         end
      end
      ptcc_cc_unit u_cc (
         .clk(CLK_SYS),
         .nrst(NRST),
         .ctl(ccc_r[g]),
         .wr(wr_ccv),
         .wdata(merge16(ccv[g], wd, WB_SEL_I[1:0])),
         .step(step_r),
         .at_zero(at_zero),
         .at_max(at_max),
         .count(cnt_r),
         .cap_evt(rise[g+1]),
         .value(ccv[g]),
         .match(match[g]),
         .cap_hit(cap_hit[g])
      );
      // shared pin: driven only in compare mode
      always_ff @(posedge CLK_SYS or negedge NRST) begin
         if (!NRST) begin
            TIMER_WAVE_OUT[g] <= 1'b0;
            TIMER_WAVE_OE[g] <= 1'b0;
         end else begin
            TIMER_WAVE_OUT[g] <= match[g];
            TIMER_WAVE_OE[g] <= !ccc_r[g].func;
         end
      end
   end

   // flags: set beats write-one-to-clear in the same cycle
   logic [FW-1:0] flag_set, flag_clr;
   assign flag_set = {match | cap_hit, at_zero, at_max};
   assign flag_clr = wr_ifl ? FW'(wd & {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}})
                            : '0;
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         flag_r <= '0;
         en_r <= '0;
         irq_r <= 1'b0;
      end else begin
         flag_r <= (flag_r & ~flag_clr) | flag_set;
         if (wr_ien) begin
            en_r <= FW'(merge16(16'(en_r), wd, WB_SEL_I[1:0]));
         end
         irq_r <= |(flag_r & en_r);
      end
   end
   assign IRQ = irq_r;

   // status views
   logic up_stat;
   assign up_stat = st_r == ptcc_pkg::ST_UP ||
                    (st_r == ptcc_pkg::ST_IDLE && !dn_mode);
   logic [15:0] ctl_rd, sta_rd;
   assign ctl_rd = {7'h00, pend_r, 3'h0, ctl_r.single, ctl_r.dir, 1'b0,
                    ctl_r.run};
   assign sta_rd = {14'h0000, up_stat, st_r != ptcc_pkg::ST_IDLE};

   // read mux; unmapped words read zero but are still acknowledged
   logic [15:0] rd;
   always_comb begin
      rd = 16'h0000;
      case (idx)
         `PTCC_IDX_CTL: rd = ctl_rd;
         `PTCC_IDX_LIM: rd = shadow_r;
         `PTCC_IDX_CNT: rd = cnt_r;
         `PTCC_IDX_STA: rd = sta_rd;
         `PTCC_IDX_IFL: rd = 16'(flag_r);
         `PTCC_IDX_IEN: rd = 16'(en_r);
         default: begin
            for (int i = 0; i < NCC; i++) begin
               if (idx == `PTCC_IDX_CCC + 6'(i)) begin
                  rd = {9'h000, ccc_r[i].load, 3'h0, ccc_r[i].func};
               end
               if (idx == `PTCC_IDX_CCV + 6'(i)) begin
                  rd = ccv[i];
               end
            end
         end
      endcase
   end

   // answer one cycle after the request, data captured with it
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= req;
         if (req) begin
            WB_DAT_O <= {16'h0000, rd};
         end
      end
   end

   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   chk_preset_zero: assert property (preset_w && !preset_dn |=>
      cnt_r == 16'h0000) else $error("preset did not clear count");
   chk_preset_load: assert property (preset_w && preset_dn |=>
      cnt_r == $past(max_eff)) else $error("preset did not load limit");
   chk_up_wrap: assert property (tick && ctl_r.run && !preset_w &&
      st_r == ptcc_pkg::ST_UP && !ud_mode && cnt_r >= max_eff |=>
      cnt_r == 16'h0000) else $error("up count did not wrap");
   chk_up_step: assert property (tick && ctl_r.run && !preset_w &&
      st_r == ptcc_pkg::ST_UP && cnt_r < max_eff |=>
      cnt_r == 16'($past(cnt_r) + 16'h0001)) else $error("bad up step");
   chk_down_reload: assert property (tick && ctl_r.run &&
      st_r == ptcc_pkg::ST_DOWN && !ud_mode && !preset_w &&
      cnt_r == 16'h0000 |=> cnt_r == $past(max_eff))
      else $error("underflow did not reload limit");
   chk_halt_idle: assert property (halt && !wr_ctl |=>
      !ctl_r.run ##1 st_r == ptcc_pkg::ST_IDLE)
      else $error("single pass did not halt");
   chk_busy_stop: assert property (!ctl_r.run |=>
      st_r == ptcc_pkg::ST_IDLE) else $error("busy after stop");
   chk_pend_flag: assert property (wr_lim |=> pend_r)
      else $error("limit write not reported pending");
   chk_max_flag: assert property (at_max |=> flag_r[`PTCC_FLG_MAX])
      else $error("limit flag not set");
   chk_irq_gate: assert property ((flag_r & en_r) == '0 [*2] |->
      !IRQ) else $error("interrupt without enabled flag");
   cov_oneshot: cover property (halt ##1 !ctl_r.run);
   cov_reload: cover property (step_r && dn_mode && cnt_r == max_r);
   cov_bounce: cover property (st_r == ptcc_pkg::ST_UP ##1
      st_r == ptcc_pkg::ST_DOWN);
endmodule // ptcc_top
`default_nettype wire
